// ===== hw/stack_linkage_unit.sv
// Contract
// - Push lowers pointer, then writes item
// - Pop reads at pointer, then raises it
// - Pointer holds address of newest entry
// - Byte move pushes or pops one byte; on register six it moves a word
// - Call saves linkage register on stack first
// - Call copies return address, then jumps
// - Linkage register PC: push PC, jump
// - Register six is the hardware stack
// - Trap entry pushes status then PC
// - Return recovers value pushed by call
// - Any nesting depth; a register six push below limit only sets the overflow flag
// - Stack grows from top toward lower addresses
// - Register six stack stays word aligned
// - Return: register to PC, then pop register
`timescale 1ns/1ps
`include "stack_linkage_defines.svh"
module stack_linkage_unit
  import stack_linkage_pkg::*;
#(
  parameter logic [15:0] STACK_LIMIT = `STACK_LIMIT_DEF
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        cmd_valid_in,
  input  wire op_t         cmd_op_in,
  input  wire logic [2:0]  cmd_reg_in,
  input  wire logic        cmd_byte_in,
  input  wire logic [15:0] cmd_data_in,
  input  wire logic [15:0] cmd_entry_in,
  input  wire logic [15:0] cmd_status_in,
  output logic             cmd_ready_out,
  output logic             done_out,
  output logic [15:0]      result_out,
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic             mem_byte_out,
  output logic [15:0]      mem_addr_out,
  output logic [15:0]      mem_wdata_out,
  input  wire logic        mem_ack_in,
  input  wire logic [15:0] mem_rdata_in,
  input  wire logic        overflow_clear_in,
  output logic             stack_overflow_out
);
  state_t      state;
  state_t      next_state;
  op_t         op;
  logic [2:0]  sel;
  logic        byte_mode;
  logic [15:0] data;
  logic [15:0] entry;
  logic [15:0] status;
  logic [15:0] ptr;
  logic [15:0] aux;
  logic [15:0] pc_val;
  logic [15:0] push_word;
  logic [15:0] pop_val;
  logic        second;
  logic [2:0]  ptr_idx;
  logic [15:0] step;
  logic [15:0] push_addr;
  logic [15:0] pop_addr;
  logic [15:0] pop_value;
  logic [7:0]  pop_lane;

  reg_port_if rf ();

  general_reg_file #(
    .NUM_REGS (8)
  ) u_regs (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .port       (rf)
  );

  // ----------------------------------------------------------------
  // Pointer arithmetic
  // ----------------------------------------------------------------
  // Hardware stack choice
  assign ptr_idx = (op == OP_PUSH || op == OP_POP || op == OP_SET_REG ||
                    op == OP_GET_REG) ? sel : `HW_STACK_IDX;
  assign step = (byte_mode && ptr_idx != `HW_STACK_IDX) ? `STEP_BYTE : `STEP_WORD;
  assign push_addr = (ptr_idx == `HW_STACK_IDX) ? ((ptr - step) & 16'hfffe)
                                                : (ptr - step);
  assign pop_addr = (ptr_idx == `HW_STACK_IDX) ? (ptr & 16'hfffe) : ptr;
  assign pop_lane = pop_addr[0] ? mem_rdata_in[15:8] : mem_rdata_in[7:0];
  assign pop_value = (byte_mode && ptr_idx != `HW_STACK_IDX)
                     ? {{8{pop_lane[7]}}, pop_lane} : mem_rdata_in;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmd_valid_in) begin
          next_state = ST_FETCH_PTR;
        end
      end
      ST_FETCH_PTR: next_state = ST_FETCH_AUX;
      ST_FETCH_AUX: next_state = ST_FETCH_PC;
      ST_FETCH_PC:  next_state = ST_DECIDE;
      ST_DECIDE: begin
        case (op)
          OP_PUSH, OP_CALL, OP_TRAP: next_state = ST_PUSH;
          OP_POP:                    next_state = ST_POP;
          OP_RETURN:                 next_state = ST_RET_PC;
          OP_SET_REG:                next_state = ST_SET;
          default:                   next_state = ST_FINISH;
        endcase
      end
      ST_PUSH: next_state = ST_PUSH_WAIT;
      ST_PUSH_WAIT: begin
        if (mem_ack_in) begin
          if (op == OP_TRAP && !second) begin
            next_state = ST_PUSH;
          end else if (op == OP_CALL) begin
            next_state = ST_LINK;
          end else begin
            next_state = ST_FINISH;
          end
        end
      end
      ST_LINK:   next_state = ST_JUMP;
      ST_JUMP:   next_state = ST_FINISH;
      ST_RET_PC: next_state = ST_POP;
      ST_POP:    next_state = ST_POP_WAIT;
      ST_POP_WAIT: begin
        if (mem_ack_in) begin
          next_state = (op == OP_RETURN) ? ST_POP_DEST : ST_FINISH;
        end
      end
      ST_POP_DEST: next_state = ST_FINISH;
      ST_SET:      next_state = ST_FINISH;
      ST_FINISH:   next_state = ST_IDLE;
      default:     next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      op        <= OP_PUSH;
      sel       <= 3'h0;
      byte_mode <= 1'b0;
      data      <= 16'h0000;
      entry     <= 16'h0000;
      status    <= 16'h0000;
    end else if (state == ST_IDLE && cmd_valid_in) begin
      op        <= cmd_op_in;
      sel       <= cmd_reg_in;
      byte_mode <= cmd_byte_in && (cmd_op_in == OP_PUSH || cmd_op_in == OP_POP);
      data      <= cmd_data_in;
      entry     <= cmd_entry_in;
      status    <= cmd_status_in;
    end
  end

  // ----------------------------------------------------------------
  // Working values
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ptr       <= 16'h0000;
      aux       <= 16'h0000;
      pc_val    <= 16'h0000;
      push_word <= 16'h0000;
      pop_val   <= 16'h0000;
      second    <= 1'b0;
    end else begin
      case (state)
        ST_FETCH_AUX: ptr <= rf.rd_data;
        ST_FETCH_PC:  aux <= rf.rd_data;
        ST_DECIDE: begin
          pc_val <= rf.rd_data;
          second <= 1'b0;
          case (op)
            OP_CALL: push_word <= aux;
            OP_TRAP: push_word <= status;
            default: push_word <= data;
          endcase
        end
        ST_PUSH: ptr <= push_addr;
        ST_PUSH_WAIT: begin
          if (mem_ack_in && op == OP_TRAP && !second) begin
            push_word <= pc_val;
            second    <= 1'b1;
          end
        end
        ST_POP_WAIT: begin
          if (mem_ack_in) begin
            pop_val <= pop_value;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register file access
  // ----------------------------------------------------------------
  always_comb begin
    rf.rd_addr = 3'h0;
    rf.wr_en   = 1'b0;
    rf.wr_addr = 3'h0;
    rf.wr_data = 16'h0000;
    case (state)
      ST_FETCH_PTR: rf.rd_addr = ptr_idx;
      ST_FETCH_AUX: rf.rd_addr = sel;
      ST_FETCH_PC:  rf.rd_addr = `PC_IDX;
      ST_PUSH: begin
        rf.wr_en   = 1'b1;
        rf.wr_addr = ptr_idx;
        rf.wr_data = push_addr;
      end
      ST_POP_WAIT: begin
        rf.wr_en   = mem_ack_in;
        rf.wr_addr = ptr_idx;
        rf.wr_data = ptr + step;
      end
      ST_LINK: begin
        rf.wr_en   = 1'b1;
        rf.wr_addr = sel;
        rf.wr_data = pc_val;
      end
      ST_JUMP: begin
        rf.wr_en   = 1'b1;
        rf.wr_addr = `PC_IDX;
        rf.wr_data = entry;
      end
      ST_RET_PC: begin
        rf.wr_en   = 1'b1;
        rf.wr_addr = `PC_IDX;
        rf.wr_data = aux;
      end
      ST_POP_DEST: begin
        rf.wr_en   = 1'b1;
        rf.wr_addr = sel;
        rf.wr_data = pop_val;
      end
      ST_SET: begin
        rf.wr_en   = 1'b1;
        rf.wr_addr = sel;
        rf.wr_data = data;
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Memory port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_req_out   <= 1'b0;
      mem_we_out    <= 1'b0;
      mem_byte_out  <= 1'b0;
      mem_addr_out  <= 16'h0000;
      mem_wdata_out <= 16'h0000;
    end else if (state == ST_PUSH) begin
      mem_req_out   <= 1'b1;
      mem_we_out    <= 1'b1;
      mem_byte_out  <= byte_mode && ptr_idx != `HW_STACK_IDX;
      mem_addr_out  <= push_addr;
      mem_wdata_out <= (byte_mode && ptr_idx != `HW_STACK_IDX)
                       ? {push_word[7:0], push_word[7:0]} : push_word;
    end else if (state == ST_POP) begin
      mem_req_out  <= 1'b1;
      mem_we_out   <= 1'b0;
      mem_byte_out <= byte_mode && ptr_idx != `HW_STACK_IDX;
      mem_addr_out <= pop_addr;
    end else if ((state == ST_PUSH_WAIT || state == ST_POP_WAIT) && mem_ack_in) begin
      mem_req_out <= 1'b0;
      mem_we_out  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Handshake and results
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_ready_out <= 1'b1;
      done_out      <= 1'b0;
      result_out    <= 16'h0000;
    end else begin
      cmd_ready_out <= (next_state == ST_IDLE);
      done_out      <= (state == ST_FINISH);
      if (state == ST_POP_WAIT && mem_ack_in) begin
        result_out <= pop_value;
      end else if (state == ST_DECIDE && op == OP_GET_REG) begin
        result_out <= ptr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stack bound check
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stack_overflow_out <= 1'b0;
    end else if (state == ST_PUSH && ptr_idx == `HW_STACK_IDX &&
                 push_addr < STACK_LIMIT) begin
      stack_overflow_out <= 1'b1;
    end else if (overflow_clear_in) begin
      stack_overflow_out <= 1'b0;
    end
  end
endmodule

// ===== hw/stack_linkage_defines.svh
`ifndef STACK_LINKAGE_DEFINES_SVH
`define STACK_LINKAGE_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define HW_STACK_IDX    3'h6
`define PC_IDX          3'h7

// ----------------------------------------------------------------
// Pointer steps, reset value and default stack limit
// ----------------------------------------------------------------
`define STEP_WORD       16'h0002
`define STEP_BYTE       16'h0001
`define REG_RESET       16'h0000
`define STACK_LIMIT_DEF 16'h0400

`endif

// ===== hw/stack_linkage_pkg.sv
package stack_linkage_pkg;

  // Commands accepted on the command port
  typedef enum logic [2:0] {
    OP_PUSH,
    OP_POP,
    OP_CALL,
    OP_RETURN,
    OP_TRAP,
    OP_SET_REG,
    OP_GET_REG
  } op_t;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_FETCH_PTR,
    ST_FETCH_AUX,
    ST_FETCH_PC,
    ST_DECIDE,
    ST_PUSH,
    ST_PUSH_WAIT,
    ST_LINK,
    ST_JUMP,
    ST_RET_PC,
    ST_POP,
    ST_POP_WAIT,
    ST_POP_DEST,
    ST_SET,
    ST_FINISH
  } state_t;

endpackage

// ===== hw/reg_port_if.sv
`timescale 1ns/1ps
interface reg_port_if;
  logic [2:0]  rd_addr;
  logic [15:0] rd_data;
  logic        wr_en;
  logic [2:0]  wr_addr;
  logic [15:0] wr_data;

  modport ctrl (output rd_addr, output wr_en, output wr_addr, output wr_data,
                input rd_data);
  modport store (input rd_addr, input wr_en, input wr_addr, input wr_data,
                 output rd_data);
endinterface

// ===== hw/general_reg_file.sv
`timescale 1ns/1ps
`include "stack_linkage_defines.svh"
module general_reg_file #(
  parameter int NUM_REGS = 8
) (
  input  wire logic  ref_clk_in,
  input  wire logic  rst_in,
  reg_port_if.store  port
);
  logic [15:0] regs [NUM_REGS];

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NUM_REGS; i++) begin : g_reg
      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          regs[i] <= `REG_RESET;
        end else if (port.wr_en && (port.wr_addr == 3'(i))) begin
          regs[i] <= port.wr_data;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered read
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      port.rd_data <= `REG_RESET;
    end else begin
      port.rd_data <= regs[port.rd_addr];
    end
  end
endmodule

// ===== tb/stack_linkage_unit_asserts.sv
`timescale 1ns/1ps
`include "stack_linkage_defines.svh"
module stack_linkage_unit_asserts
  import stack_linkage_pkg::*;
#(
  parameter logic [15:0] STACK_LIMIT = `STACK_LIMIT_DEF
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        cmd_valid_in,
  input  wire op_t         cmd_op_in,
  input  wire logic [2:0]  cmd_reg_in,
  input  wire logic        cmd_byte_in,
  input  wire logic [15:0] cmd_data_in,
  input  wire logic        cmd_ready_out,
  input  wire logic        mem_req_out,
  input  wire logic        mem_we_out,
  input  wire logic        mem_byte_out,
  input  wire logic [15:0] mem_addr_out,
  input  wire logic [15:0] mem_wdata_out,
  input  wire logic        mem_ack_in,
  input  wire logic        stack_overflow_out
);
  op_t         op_q;
  logic [2:0]  reg_q;
  logic        byte_q;
  logic [15:0] data_q;
  logic        hw;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // ------------------------------
  // Accepted command
  // ------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      op_q   <= OP_GET_REG;
      reg_q  <= 3'h0;
      byte_q <= 1'b0;
      data_q <= 16'h0000;
    end else if (cmd_valid_in && cmd_ready_out) begin
      op_q   <= cmd_op_in;
      reg_q  <= cmd_reg_in;
      byte_q <= cmd_byte_in;
      data_q <= cmd_data_in;
    end
  end

  assign hw = mem_req_out && ((op_q != OP_PUSH && op_q != OP_POP) || reg_q == `HW_STACK_IDX);

  // ------------------------------
  // Checks
  // ------------------------------
  a_push_writes: assert property (
    mem_req_out && (op_q == OP_PUSH || op_q == OP_CALL || op_q == OP_TRAP) |-> mem_we_out)
    else $error("push access is not a write");
  a_pop_reads: assert property (
    mem_req_out && (op_q == OP_POP || op_q == OP_RETURN) |-> !mem_we_out)
    else $error("pop access writes memory");
  a_push_data: assert property (
    mem_req_out && op_q == OP_PUSH
      |-> mem_wdata_out == (mem_byte_out ? {2{data_q[7:0]}} : data_q))
    else $error("pushed data wrong");
  a_hw_even: assert property (
    hw |-> !mem_addr_out[0] && !mem_byte_out)
    else $error("hardware stack access not a word");
  a_byte_only: assert property (
    mem_req_out && mem_byte_out
      |-> (op_q == OP_PUSH || op_q == OP_POP) && byte_q && reg_q != `HW_STACK_IDX)
    else $error("byte access without byte command");
  a_req_held: assert property (
    mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out))
    else $error("memory request dropped early");
  a_ovf_flag: assert property (
    hw && mem_we_out && mem_ack_in && mem_addr_out < STACK_LIMIT |-> ##[0:2] stack_overflow_out)
    else $error("overflow not flagged");
  a_idle_bus: assert property (
    cmd_ready_out |-> !mem_req_out)
    else $error("memory access while idle");
endmodule

bind stack_linkage_unit stack_linkage_unit_asserts #(.STACK_LIMIT(STACK_LIMIT)) chk (
  .ref_clk_in, .rst_in, .cmd_valid_in, .cmd_op_in, .cmd_reg_in, .cmd_byte_in,
  .cmd_data_in, .cmd_ready_out, .mem_req_out, .mem_we_out, .mem_byte_out,
  .mem_addr_out, .mem_wdata_out, .mem_ack_in, .stack_overflow_out);

// ===== tb/stack_mem_model.sv
`timescale 1ns/1ps
module stack_mem_model (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        slow_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic        byte_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] wdata_in,
  output logic             ack_out,
  output logic [15:0]      rdata_out
);
  logic [15:0] mem [0:255];
  logic [1:0]  wait_cnt;
  logic [7:0]  idx;

  assign idx = addr_in[8:1];

  // Read data is only valid with ack; it toggles otherwise
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out   <= 1'b0;
      wait_cnt  <= 2'h0;
      rdata_out <= 16'h0000;
    end else begin
      ack_out   <= 1'b0;
      rdata_out <= ~rdata_out;
      if (req_in && !ack_out) begin
        if (slow_in && wait_cnt != 2'h3) begin
          wait_cnt <= wait_cnt + 2'h1;
        end else begin
          wait_cnt <= 2'h0;
          ack_out  <= 1'b1;
          if (!we_in) begin
            rdata_out <= mem[idx];
          end else if (!byte_in) begin
            mem[idx] <= wdata_in;
          end else if (addr_in[0]) begin
            mem[idx][15:8] <= wdata_in[15:8];
          end else begin
            mem[idx][7:0] <= wdata_in[7:0];
          end
        end
      end
    end
  end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import stack_linkage_pkg::*;
  logic        ref_clk_in, rst_in, cmd_valid_in, cmd_byte_in, cmd_ready_out, done_out;
  logic        mem_req_out, mem_we_out, mem_byte_out, mem_ack_in, slow;
  logic        overflow_clear_in, stack_overflow_out;
  op_t         cmd_op_in;
  logic [2:0]  cmd_reg_in;
  logic [15:0] cmd_data_in, result_out, mem_addr_out, mem_wdata_out, mem_rdata_in;
  logic [15:0] cmd_entry_in, cmd_status_in;
  int          errors, compares, cycles;

  stack_linkage_unit DUT (
    .ref_clk_in, .rst_in, .cmd_valid_in, .cmd_op_in, .cmd_reg_in, .cmd_byte_in,
    .cmd_data_in, .cmd_entry_in, .cmd_status_in,
    .cmd_ready_out, .done_out, .result_out, .mem_req_out, .mem_we_out, .mem_byte_out,
    .mem_addr_out, .mem_wdata_out, .mem_ack_in, .mem_rdata_in, .overflow_clear_in,
    .stack_overflow_out);

  stack_mem_model mem_m (
    .ref_clk_in, .rst_in, .slow_in(slow), .req_in(mem_req_out), .we_in(mem_we_out),
    .byte_in(mem_byte_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
    .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic close_out;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [15:0] mw(input logic [15:0] a);
    return mem_m.mem[a[8:1]];
  endfunction

  task automatic cmd(input op_t op, input logic [2:0] r, input logic [15:0] d);
    int n;
    n = 0;
    cmd_op_in    <= op;
    cmd_reg_in   <= r;
    cmd_data_in   <= (op == OP_CALL || op == OP_TRAP) ? ~d : d;
    cmd_entry_in  <= (op == OP_CALL) ? d : ~d;
    cmd_status_in <= (op == OP_TRAP) ? d : ~d;
    cmd_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    cmd_valid_in <= 1'b0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (done_out !== 1'b1 && n < 200);
    if (n >= 200) begin
      errors++;
      $display("[FAIL] done expected 1 seen %b", done_out);
    end
    @(posedge ref_clk_in);
  endtask

  task automatic get(input logic [2:0] r, input logic [15:0] e);
    cmd(OP_GET_REG, r, 16'h0000);
    check("register", result_out, e);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_word;
    slow <= 1'b1;
    cmd(OP_SET_REG, 3'h3, 16'h0480);
    cmd(OP_PUSH, 3'h3, 16'h1234);
    get(3'h3, 16'h047e);
    check("push mem", mw(16'h047e), 16'h1234);
    cmd(OP_POP, 3'h3, 16'h0000);
    check("pop data", result_out, 16'h1234);
    get(3'h3, 16'h0480);
    check("pop keeps", mw(16'h047e), 16'h1234);
    slow <= 1'b0;
  endtask

  task automatic t_byte;
    cmd_byte_in <= 1'b1;
    cmd(OP_SET_REG, 3'h2, 16'h0441);
    cmd(OP_PUSH, 3'h2, 16'h00a5);
    get(3'h2, 16'h0440);
    check("byte lane", mw(16'h0440) & 16'h00ff, 16'h00a5);
    cmd(OP_PUSH, 3'h2, 16'h003c);
    check("odd lane", mw(16'h043f) & 16'hff00, 16'h3c00);
    get(3'h2, 16'h043f);
    cmd(OP_POP, 3'h2, 16'h0000);
    check("odd pop", result_out, 16'h003c);
    cmd(OP_POP, 3'h2, 16'h0000);
    check("byte pop", result_out, 16'hffa5);
    get(3'h2, 16'h0441);
    cmd(OP_SET_REG, 3'h6, 16'h0480);
    cmd(OP_PUSH, 3'h6, 16'h7777);
    get(3'h6, 16'h047e);
    check("hw word", mw(16'h047e), 16'h7777);
    cmd_byte_in <= 1'b0;
  endtask

  task automatic t_call;
    cmd(OP_SET_REG, 3'h6, 16'h0480);
    cmd(OP_SET_REG, 3'h5, 16'h1111);
    cmd(OP_SET_REG, 3'h7, 16'h2000);
    cmd(OP_CALL, 3'h5, 16'h3000);
    check("saved link", mw(16'h047e), 16'h1111);
    get(3'h5, 16'h2000);
    get(3'h7, 16'h3000);
    cmd(OP_RETURN, 3'h5, 16'h0000);
    get(3'h7, 16'h2000);
    get(3'h5, 16'h1111);
    get(3'h6, 16'h0480);
    cmd(OP_CALL, 3'h7, 16'h4000);
    check("saved pc", mw(16'h047e), 16'h2000);
    get(3'h7, 16'h4000);
    cmd(OP_RETURN, 3'h7, 16'h0000);
    get(3'h7, 16'h2000);
  endtask

  task automatic t_trap;
    slow <= 1'b1;
    cmd(OP_SET_REG, 3'h6, 16'h0404);
    cmd(OP_SET_REG, 3'h7, 16'h1000);
    cmd(OP_TRAP, 3'h0, 16'h00e0);
    check("trap status", mw(16'h0402), 16'h00e0);
    check("trap pc", mw(16'h0400), 16'h1000);
    check("no overflow", {15'h0000, stack_overflow_out}, 16'h0000);
    cmd(OP_CALL, 3'h7, 16'h5000);
    check("nest pc", mw(16'h03fe), 16'h1000);
    check("overflow", {15'h0000, stack_overflow_out}, 16'h0001);
    overflow_clear_in <= 1'b1;
    @(posedge ref_clk_in);
    overflow_clear_in <= 1'b0;
    @(negedge ref_clk_in);
    check("cleared", {15'h0000, stack_overflow_out}, 16'h0000);
    @(posedge ref_clk_in);
    slow <= 1'b0;
  endtask

  task automatic t_reset;
    cmd(OP_PUSH, 3'h6, 16'h0000);
    check("flag again", {15'h0000, stack_overflow_out}, 16'h0001);
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    check("reset flag", {15'h0000, stack_overflow_out}, 16'h0000);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    get(3'h6, 16'h0000);
  endtask

  // ------------------------------
  // Clock, watchdog, sequence
  // ------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out;
    end
  end

  initial begin
    rst_in = 1'b1;
    cmd_valid_in = 1'b0;
    cmd_op_in = OP_GET_REG;
    cmd_reg_in = 3'h0;
    cmd_byte_in = 1'b0;
    cmd_data_in = 16'h0000;
    cmd_entry_in = 16'h0000;
    cmd_status_in = 16'h0000;
    overflow_clear_in = 1'b0;
    slow = 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    get(3'h4, 16'h0000);
    t_word;
    t_byte;
    t_call;
    t_trap;
    t_reset;
    close_out;
  end
endmodule
